// File: plw_pkg.sv
// Purpose: Shared constants for the program loop watchdog.
// Assumes: One system clock at 40 MHz; low-speed ticks made by a divider.
// Notes: Option bit positions follow the option byte layout.
package plw_pkg;
   // Refresh register address and values
   localparam logic [19:0] PLW_REFRESH_ADDR = 20'hFFFAB;
   localparam logic [7:0] PLW_KEY_BYTE = 8'hAC;
   localparam logic [7:0] PLW_RESET_VAL_OFF = 8'h1A;
   localparam logic [7:0] PLW_RESET_VAL_ON = 8'h9A;
   // Option byte field positions
   localparam int PLW_OPT_ENABLE_BIT = 4;
   localparam int PLW_OPT_SEL_LSB = 1;
   localparam int PLW_OPT_STBY_BIT = 0;
   // Clock rates
   localparam int PLW_SYS_CLK_HZ = 40000000;
   localparam int PLW_LOW_CLK_HZ = 17250;
   localparam int PLW_LOW_DIV = PLW_SYS_CLK_HZ / PLW_LOW_CLK_HZ;
   // Counter width covers the longest timeout
   localparam int PLW_CNT_W = 16;
   // Overflow exponent per timeout select code
   function automatic logic [4:0] plw_exp(input logic [2:0] sel);
      logic [4:0] e;
      e = 5'h06;
      unique case (sel)
         3'h0: e = 5'h06;
         3'h1: e = 5'h07;
         3'h2: e = 5'h08;
         3'h3: e = 5'h09;
         3'h4: e = 5'h0B;
         3'h5: e = 5'h0D;
         3'h6: e = 5'h0E;
         3'h7: e = 5'h10;
      endcase
      return e;
   endfunction : plw_exp
endpackage : plw_pkg

// File: plw_tick_div.sv
// Purpose: Makes the one-cycle low-speed tick enable.
// Assumes: DIV at least 2.
// Notes: Tick is the only low-speed clock the counter sees.
`timescale 1ns/1ps
module plw_tick_div #(
   parameter int DIV = 2318
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // Tick
   output logic tick_out
);
   logic [15:0] cnt_ff;
   initial begin
      if (DIV < 2 || DIV > 65535) $error("plw_tick_div: DIV out of range");
   end
   // Free-running divider
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt_ff <= 16'h0000;
         tick_out <= 1'b0;
      end else if (cnt_ff == 16'(DIV - 1)) begin
         cnt_ff <= 16'h0000;
         tick_out <= 1'b1;
      end else begin
         cnt_ff <= cnt_ff + 16'h0001;
         tick_out <= 1'b0;
      end
   end
endmodule : plw_tick_div

// File: plw_opt_latch.sv
// Purpose: Captures option bits once after reset release.
// Assumes: Option byte is stable around reset release.
// Notes: Captured by a clocked load, never by the async reset.
`timescale 1ns/1ps
module plw_opt_latch
   import plw_pkg::*;
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // Option byte
   input wire logic [7:0] opt_in,
   // Captured options
   output logic enable_out,
   output logic [2:0] sel_out,
   output logic stby_out,
   output logic valid_out
);
   // Load on first edge after release
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         enable_out <= 1'b0;
         sel_out <= 3'h0;
         stby_out <= 1'b0;
         valid_out <= 1'b0;
      end else if (!valid_out) begin
         enable_out <= opt_in[PLW_OPT_ENABLE_BIT];
         sel_out <= opt_in[PLW_OPT_SEL_LSB +: 3];
         stby_out <= opt_in[PLW_OPT_STBY_BIT];
         valid_out <= 1'b1;
      end
   end
endmodule : plw_opt_latch

// File: plw_watchdog.sv
// Purpose: Program loop watchdog with key-byte refresh and interval interrupt.
// Assumes: CPU bus strobes synchronous to MCLK_IN; low-speed clock is a tick enable.
// Notes: Reset request and interrupt leave as one-cycle pulses from flip-flops.
`timescale 1ns/1ps
module plw_watchdog
   import plw_pkg::*;
#(
   parameter int LOW_DIV = PLW_LOW_DIV
) (
   // Clock and reset
   input wire logic MCLK_IN,
   input wire logic NRST_IN,
   // Option byte
   input wire logic [7:0] OPTION_BYTE_IN,
   // CPU register access
   input wire logic [19:0] ADDR_IN,
   input wire logic [7:0] WDATA_IN,
   input wire logic WR_IN,
   input wire logic RD_IN,
   input wire logic BIT_ACCESS_IN,
   output logic [7:0] RDATA_OUT,
   // Power state
   input wire logic STANDBY_IN,
   // Requests
   output logic RESET_REQ_OUT,
   output logic INTERVAL_IRQ_OUT,
   output logic DOG_RESET_CAUSE_OUT
);
   logic tick;
   logic opt_en;
   logic [2:0] opt_sel;
   logic opt_stby;
   logic opt_valid;
   logic [PLW_CNT_W-1:0] cnt_ff;
   logic standby_d_ff;
   logic irq_done_ff;
   logic cause_ff;
   logic hit;
   logic key_ok;
   logic bad_access;
   logic running;
   logic [PLW_CNT_W:0] full_cnt;
   logic [PLW_CNT_W-1:0] ovf_cnt;
   logic [PLW_CNT_W-1:0] irq_cnt;
   logic overflow;
   logic irq_hit;

   initial begin
      if (LOW_DIV < 2) $error("plw_watchdog: LOW_DIV too small");
   end

   // Low-speed tick
   plw_tick_div #(.DIV(LOW_DIV)) u_div (
      .clk_in(MCLK_IN),
      .rst_n_in(NRST_IN),
      .tick_out(tick)
   );

   // Option capture
   plw_opt_latch u_opt (
      .clk_in(MCLK_IN),
      .rst_n_in(NRST_IN),
      .opt_in(OPTION_BYTE_IN),
      .enable_out(opt_en),
      .sel_out(opt_sel),
      .stby_out(opt_stby),
      .valid_out(opt_valid)
   );

   // Access decode
   assign hit = WR_IN && (ADDR_IN == PLW_REFRESH_ADDR);
   assign bad_access = hit && (BIT_ACCESS_IN || (WDATA_IN != PLW_KEY_BYTE));
   assign key_ok = hit && !BIT_ACCESS_IN && (WDATA_IN == PLW_KEY_BYTE);

   assign full_cnt = (PLW_CNT_W + 1)'(1) << plw_exp(opt_sel);
   assign ovf_cnt = PLW_CNT_W'(full_cnt - (PLW_CNT_W + 1)'(1));
   assign irq_cnt = PLW_CNT_W'((full_cnt >> 1) + (full_cnt >> 2));

   // Enable gates counting; standby stops unless run option set
   assign running = opt_valid && opt_en && (!STANDBY_IN || opt_stby);
   // Overflow at limit; refresh in same cycle wins
   assign overflow = running && tick && (cnt_ff == ovf_cnt - 1'b1) && !key_ok;
   assign irq_hit = running && !irq_done_ff && (cnt_ff >= irq_cnt);

   // Standby edge tracking
   always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         standby_d_ff <= 1'b0;
      end else begin
         standby_d_ff <= STANDBY_IN;
      end
   end

   // Counter
   always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         cnt_ff <= '0;
      end else if (key_ok) begin
         cnt_ff <= '0;
      end else if (standby_d_ff && !STANDBY_IN && !opt_stby) begin
         cnt_ff <= '0;
      end else if (overflow) begin
         cnt_ff <= '0;
      end else if (running && tick) begin
         // Advance on low tick; continues past interrupt
         cnt_ff <= cnt_ff + 1'b1;
      end
   end

   // Interrupt armed once per count period
   always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         irq_done_ff <= 1'b0;
         INTERVAL_IRQ_OUT <= 1'b0;
      end else begin
         INTERVAL_IRQ_OUT <= irq_hit && !key_ok;
         if (key_ok || cnt_ff == '0) begin
            irq_done_ff <= 1'b0;
         end else if (irq_hit) begin
            irq_done_ff <= 1'b1;
         end
      end
   end

   // Reset request pulse
   always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         RESET_REQ_OUT <= 1'b0;
      end else begin
         RESET_REQ_OUT <= overflow || bad_access;
      end
   end

   // Cause flag held in this block, cleared only by the NRST_IN reset
   always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         cause_ff <= 1'b0;
      end else if (overflow || bad_access) begin
         cause_ff <= 1'b1;
      end
   end
   assign DOG_RESET_CAUSE_OUT = cause_ff;

   // Read data
   always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         RDATA_OUT <= 8'h00;
      end else if (RD_IN && ADDR_IN == PLW_REFRESH_ADDR) begin
         // Reset value by option; never the key
         RDATA_OUT <= opt_en ? PLW_RESET_VAL_ON : PLW_RESET_VAL_OFF;
      end else begin
         RDATA_OUT <= 8'h00;
      end
   end

   // Assertions
   a_bad_write_resets: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
      bad_access |=> RESET_REQ_OUT) else $error("bad write did not reset");
   a_key_clears_cnt: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
      key_ok |=> cnt_ff == '0) else $error("key did not clear");
   a_stopped_when_off: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
      !opt_en |=> cnt_ff == '0) else $error("counter ran while off");
   a_reset_pulse_one: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
      RESET_REQ_OUT && !$past(bad_access) |=> !RESET_REQ_OUT)
      else $error("reset pulse too long");
   a_cause_follows: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
      RESET_REQ_OUT |-> cause_ff) else $error("cause flag missing");
   a_read_value: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
      RD_IN && ADDR_IN == PLW_REFRESH_ADDR |=> RDATA_OUT != PLW_KEY_BYTE)
      else $error("read returned key");
   a_standby_hold: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
      STANDBY_IN && !opt_stby && $past(STANDBY_IN) |=> $stable(cnt_ff))
      else $error("counter moved in standby");
   a_irq_at_level: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
      INTERVAL_IRQ_OUT |-> $past(cnt_ff) >= $past(irq_cnt))
      else $error("interrupt early");
endmodule : plw_watchdog

// File: plw_watchdog_tb.sv
// Purpose: Self-checking bench for the program loop watchdog.
// Assumes: LOW_DIV of 2 keeps the timeouts of selects 0 to 6 short; system reset is applied by the bench.
// Notes: Tick phase against a refresh is unknown, so times are checked within one tick.
`timescale 1ns/1ps
module plw_watchdog_tb;
   import plw_pkg::*;
   localparam int D = 2;
   logic MCLK_IN, NRST_IN, WR_IN, RD_IN, BIT_ACCESS_IN, STANDBY_IN;
   logic [7:0] OPTION_BYTE_IN, WDATA_IN, RDATA_OUT, d;
   logic [19:0] ADDR_IN;
   logic RESET_REQ_OUT, INTERVAL_IRQ_OUT, DOG_RESET_CAUSE_OUT;
   logic [31:0] seed = 32'h0000AD1B;
   int n_fail = 0;
   int checks = 0;
   int cyc, k, t;
   int exp_n[8] = '{6, 7, 8, 9, 11, 13, 14, 16};

   plw_watchdog #(.LOW_DIV(D)) dut_u (.MCLK_IN(MCLK_IN), .NRST_IN(NRST_IN),
      .OPTION_BYTE_IN(OPTION_BYTE_IN), .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .WR_IN(WR_IN),
      .RD_IN(RD_IN), .BIT_ACCESS_IN(BIT_ACCESS_IN), .RDATA_OUT(RDATA_OUT),
      .STANDBY_IN(STANDBY_IN), .RESET_REQ_OUT(RESET_REQ_OUT),
      .INTERVAL_IRQ_OUT(INTERVAL_IRQ_OUT), .DOG_RESET_CAUSE_OUT(DOG_RESET_CAUSE_OUT));

   // 40 MHz system clock
   initial begin
      MCLK_IN = 1'b0;
      forever #12.5 MCLK_IN = ~MCLK_IN;
   end

   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction : xs

   task automatic chk1(input string nm, input logic e, input logic g);
      checks++;
      if (g !== e) begin
         n_fail++;
         $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
      end
   endtask : chk1

   task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
      checks++;
      if (g !== e) begin
         n_fail++;
         $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
      end
   endtask : chk8

   // Options are only captured after a release, so every scenario starts here
   task automatic do_reset(input logic [7:0] opt);
      @(posedge MCLK_IN);
      NRST_IN <= 1'b0;
      OPTION_BYTE_IN <= opt;
      STANDBY_IN <= 1'b0;
      repeat (4) @(posedge MCLK_IN);
      NRST_IN <= 1'b1;
      repeat (2) @(posedge MCLK_IN);
   endtask : do_reset

   task automatic wr(input logic [7:0] v, input logic b);
      @(posedge MCLK_IN);
      WR_IN <= 1'b1;
      ADDR_IN <= PLW_REFRESH_ADDR;
      WDATA_IN <= v;
      BIT_ACCESS_IN <= b;
      @(posedge MCLK_IN);
      WR_IN <= 1'b0;
      BIT_ACCESS_IN <= 1'b0;
   endtask : wr

   task automatic rd(input logic [19:0] a, input logic [7:0] e, input string nm);
      @(posedge MCLK_IN);
      RD_IN <= 1'b1;
      ADDR_IN <= a;
      @(posedge MCLK_IN);
      RD_IN <= 1'b0;
      #1 chk8(nm, e, RDATA_OUT);
   endtask : rd

   // Counts edges until the chosen pulse shows, giving up at lim
   task automatic wait_ev(input logic rst_sel, input int lim);
      cyc = 0;
      while (cyc < lim) begin
         @(posedge MCLK_IN);
         #1;
         cyc++;
         if ((rst_sel ? RESET_REQ_OUT : INTERVAL_IRQ_OUT) === 1'b1) break;
      end
   endtask : wait_ev

   task automatic wrap_up;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : wrap_up

   // Longest path is about 60k cycles; 100k cycles means a hang
   initial begin
      #2500000;
      n_fail++;
      wrap_up;
   end

   initial begin
      NRST_IN = 1'b0;
      WR_IN = 1'b0;
      RD_IN = 1'b0;
      BIT_ACCESS_IN = 1'b0;
      STANDBY_IN = 1'b0;
      OPTION_BYTE_IN = 8'h00;
      WDATA_IN = 8'h00;
      ADDR_IN = 20'h00000;
      repeat (4) @(posedge MCLK_IN);
      NRST_IN <= 1'b1;
      do_reset(8'h00);
      rd(PLW_REFRESH_ADDR, PLW_RESET_VAL_OFF, "refresh_off");
      wait_ev(1'b0, 400);
      chk1("stopped", 1'b1, cyc == 400);
      // Short timeouts only because select 7 would overflow after about 131k cycles, past the 100k-cycle limit
      for (int s = 0; s < 7; s++) begin
         do_reset({3'h0, 1'b1, s[2:0], 1'b0});
         wr(PLW_KEY_BYTE, 1'b0);
         k = 3 * (1 << exp_n[s]) / 4 * D;
         wait_ev(1'b0, k + 2 * D + 4);
         chk1("irq_time", 1'b1, cyc >= k - D && cyc <= k + D + 2);
         t = cyc;
         k = ((1 << exp_n[s]) - 1) * D;
         wait_ev(1'b1, k - t + 2 * D + 4);
         chk1("ovf_time", 1'b1, t + cyc >= k - D && t + cyc <= k + D + 2);
         chk1("ovf_cause", 1'b1, DOG_RESET_CAUSE_OUT);
      end
      // refresh before each overflow keeps the part alive
      do_reset(8'h10);
      for (int i = 0; i < 5; i++) begin
         wr(PLW_KEY_BYTE, 1'b0);
         wait_ev(1'b1, 110);
         chk1("refreshed", 1'b1, cyc == 110);
      end
      rd(PLW_REFRESH_ADDR, PLW_RESET_VAL_ON, "refresh_read");
      rd(PLW_REFRESH_ADDR ^ 20'h00001, 8'h00, "unmapped");
      // standby stops or keeps the count
      // Standby-run is only ever set together with the enable option
      for (int st = 0; st < 2; st++) begin
         do_reset({7'h08, st[0]});
         wr(PLW_KEY_BYTE, 1'b0);
         repeat (40) @(posedge MCLK_IN);
         STANDBY_IN <= 1'b1;
         wait_ev(1'b1, 200);
         chk1("standby", 1'b1, st == 0 ? cyc == 200 : cyc < 200);
         @(posedge MCLK_IN) STANDBY_IN <= 1'b0;
         if (st == 0) begin
            k = 63 * D;
            wait_ev(1'b1, k + 2 * D + 4);
            chk1("wake_clear", 1'b1, cyc >= k - D && cyc <= k + D + 2);
         end
      end
      // wrong bytes and bit access reset at once
      for (int i = 0; i < 6; i++) begin
         do_reset(8'h10);
         chk1("cause_clear", 1'b0, DOG_RESET_CAUSE_OUT);
         seed = xs(seed);
         d = (i == 5 || seed[7:0] == PLW_KEY_BYTE) ? PLW_KEY_BYTE ^ 8'h01 : seed[7:0];
         if (i >= 4) d = PLW_KEY_BYTE;
         // The request pulse stands from the write's sampling edge to the next one
         wr(d, i >= 4);
         #1 chk1("bad_req", 1'b1, RESET_REQ_OUT);
         chk1("bad_cause", 1'b1, DOG_RESET_CAUSE_OUT);
         @(posedge MCLK_IN);
         #1 chk1("req_pulse", 1'b0, RESET_REQ_OUT);
      end
      wrap_up;
   end
endmodule : plw_watchdog_tb
